/* priority_interrupt_controller.sv */
// Priority interrupt controller: per-source levels, encoding, nesting, fast vectors, wake.
// Assumes the core samples the request outputs and pulses core_ack once per taken interrupt.
//
// Contract
// - Accept 46 sources; all but the fixed ones take one of three levels.
// - Within a level the lowest-numbered active source wins; 0 most urgent.
// - Arbitrate, flag a sufficiently urgent request to the core, give its vector address.
// - In wait or stop, a pending request asks the system unit to restart clocks.
// - Only sources enabled before wait or stop entry may wake the core.
// - Normal vector address is vector base concatenated with vector number.
// - Core mask 00 allows all, 01 masks 0, 10 masks 0-1, 11 allows 3.
// - Two fast channels, each with match number and two-part handler address.
// - A level-2 winner matching a fast match number is a fast interrupt.
// - Fast interrupt address comes from that channel's low and high halves.
// - Fast recognition happens here so the address is ready at vector fetch.
// - After reset the controller drives the initial program address.
// - Eighteen software registers at module offsets from a system base.
// - Priority field 00 disables the source and is the reset value.
// - Reserved priority bits read zero and ignore writes.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module priority_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic [`NUM_SRC-1:0]   irq_src,
  input  wire logic [1:0]            core_mask,
  input  wire logic                  core_ack,
  input  wire logic                  low_power,
  input  wire logic [`ADDR_W-1:0]    addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output logic [15:0]                rdata_r,
  output logic                       core_irq_r,
  output logic [1:0]                 core_level_r,
  output logic [`VEC_W-1:0]          core_vector_r,
  output logic [`VADDR_W-1:0]        vector_addr_r,
  output logic                       fast_r,
  output logic                       wake_req_r,
  output logic                       boot_drive_r,
  output logic [`VADDR_W-1:0]        boot_addr_r,
  output logic                       irq_event_r
);

  // Register file state.
  logic [15:0]             prio_r [`NUM_PRIO];
  logic [15:0]             prio_nxt [`NUM_PRIO];
  logic [15:0]             vbase_r;
  logic [15:0]             vbase_nxt;
  logic [15:0]             match_r [2];
  logic [15:0]             match_nxt [2];
  logic [15:0]             hlo_r [2];
  logic [15:0]             hlo_nxt [2];
  logic [15:0]             hhi_r [2];
  logic [15:0]             hhi_nxt [2];
  logic [15:0]             ictrl_r;
  logic [15:0]             ictrl_nxt;
  logic [`EV_W-1:0]        evstat_r;
  logic [`EV_W-1:0]        evstat_nxt;
  logic [`EV_W-1:0]        evmask_r;
  logic [`EV_W-1:0]        evmask_nxt;
  logic [15:0]             rdata_nxt;
  logic                    irq_event_nxt;

  // Presentation and power state.
  pres_state_e             state_r;
  pres_state_e             state_nxt;
  logic                    core_irq_nxt;
  logic [1:0]              core_level_nxt;
  logic [`VEC_W-1:0]       core_vector_nxt;
  logic [`VADDR_W-1:0]     vector_addr_nxt;
  logic                    fast_nxt;
  logic                    wake_req_nxt;
  logic                    low_power_r;
  logic [`NUM_SRC-1:0]     en_snap_r;
  logic [`NUM_SRC-1:0]     en_snap_nxt;
  logic                    boot_drive_nxt;

  // Per-source decode results.
  logic [16*`NUM_PRIO-1:0] fields;
  logic [`NUM_SRC-1:0]     src_en;
  lvl_t                    src_lvl [`NUM_SRC];
  logic [`NUM_SRC-1:0]     hi_range;
  logic [`EV_W-1:0]        ev;

  // Arbitration results.
  logic                    win_valid;
  lvl_t                    win_lvl;
  logic [`VEC_W-1:0]       win_vec;
  logic                    hit0;
  logic                    hit1;

  assign fields   = {prio_r[4], prio_r[3], prio_r[2], prio_r[1], prio_r[0]};
  assign hi_range = `HI_RANGE;

  // Each source's field gives enable and level; the first few are fixed at the top level.
  for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
    if (i < `FIXED_SRC) begin : g_fixed
      assign src_en[i]  = 1'b1;
      assign src_lvl[i] = `LVL_TOP;
    end else begin : g_prog
      logic [1:0] fld;
      assign fld        = fields[2*(i-`FIXED_SRC) +: 2];
      assign src_en[i]  = |fld;
      assign src_lvl[i] = hi_range[i] ? fld : fld - 2'h1;
    end
  end

  // Walk levels upward and sources downward so the highest permitted level
  // and, within it, the lowest source number survive.
  always_comb begin
    int l;
    int i;
    logic [`NUM_SRC-1:0] act;
    l         = 0;
    i         = 0;
    act       = irq_src & src_en & {`NUM_SRC{~ictrl_r[0]}};
    win_valid = 1'b0;
    win_lvl   = 2'h0;
    win_vec   = '0;
    for (l = 0; l < 4; l++) begin
      if (l[1:0] >= core_mask) begin
        for (i = `NUM_SRC - 1; i >= 0; i--) begin
          if (act[i] && (src_lvl[i] == l[1:0])) begin
            win_valid = 1'b1;
            win_lvl   = l[1:0];
            win_vec   = i[`VEC_W-1:0];
          end
        end
      end
    end
  end

  // Fast channel match on a level-2 winner; channel 0 is checked first.
  assign hit0 = (win_lvl == `LVL_FAST) && (win_vec == match_r[0][`VEC_W-1:0]);
  assign hit1 = (win_lvl == `LVL_FAST) && (win_vec == match_r[1][`VEC_W-1:0]);

  // Presentation to the core: outputs freeze while a request is shown, so the core never
  // sees the vector change under it; the next winner is picked the clock after the ack.
  always_comb begin
    state_nxt       = state_r;
    core_irq_nxt    = core_irq_r;
    core_level_nxt  = core_level_r;
    core_vector_nxt = core_vector_r;
    vector_addr_nxt = vector_addr_r;
    fast_nxt        = fast_r;
    unique case (state_r)
      ST_IDLE: begin
        if (win_valid) begin
          state_nxt       = ST_PRESENT;
          core_irq_nxt    = 1'b1;
          core_level_nxt  = win_lvl;
          core_vector_nxt = win_vec;
          fast_nxt        = hit0 | hit1;
          if (hit0) begin
            vector_addr_nxt = {hhi_r[0][4:0], hlo_r[0]};
          end else if (hit1) begin
            vector_addr_nxt = {hhi_r[1][4:0], hlo_r[1]};
          end else begin
            vector_addr_nxt = {vbase_r[14:0], win_vec[5:0]};
          end
        end
      end
      ST_PRESENT: begin
        if (core_ack) begin
          state_nxt    = ST_IDLE;
          core_irq_nxt = 1'b0;
          fast_nxt     = 1'b0;
        end
      end
    endcase
  end

  // Wake logic: the enable set is frozen on entry so later enables cannot wake the core.
  always_comb begin
    en_snap_nxt = en_snap_r;
    if (low_power && !low_power_r) begin
      en_snap_nxt = src_en;
    end
    wake_req_nxt = low_power && low_power_r && |(irq_src & en_snap_r);
    boot_drive_nxt = 1'b0;
  end

  // Events: normal taken, fast taken, wake raised.
  assign ev = {wake_req_nxt & ~wake_req_r,
               (state_r == ST_PRESENT) & core_ack & fast_r,
               (state_r == ST_PRESENT) & core_ack & ~fast_r};

  // Register writes; reserved bits are masked off so they stay zero.
  always_comb begin
    for (int k = 0; k < `NUM_PRIO; k++) begin
      prio_nxt[k] = prio_r[k];
    end
    for (int k = 0; k < 2; k++) begin
      match_nxt[k] = match_r[k];
      hlo_nxt[k]   = hlo_r[k];
      hhi_nxt[k]   = hhi_r[k];
    end
    vbase_nxt  = vbase_r;
    ictrl_nxt  = ictrl_r;
    evmask_nxt = evmask_r;
    // A new event outranks a clear written in the same cycle.
    evstat_nxt = (evstat_r & ~((wr_en && addr == `OFF_EVSTAT) ? wdata[`EV_W-1:0] : '0)) | ev;
    if (wr_en) begin
      unique case (addr)
        `OFF_PRIO0:  prio_nxt[0]  = wdata & `PRIO0_WMASK;
        `OFF_PRIO1:  prio_nxt[1]  = wdata & `PRIO1_WMASK;
        `OFF_PRIO2:  prio_nxt[2]  = wdata & `PRIO_WMASK;
        `OFF_PRIO3:  prio_nxt[3]  = wdata & `PRIO_WMASK;
        `OFF_PRIO4:  prio_nxt[4]  = wdata & `PRIO_WMASK;
        `OFF_VBASE:  vbase_nxt    = wdata & `VBASE_WMASK;
        `OFF_MATCH0: match_nxt[0] = wdata & `MATCH_WMASK;
        `OFF_HLO0:   hlo_nxt[0]   = wdata;
        `OFF_HHI0:   hhi_nxt[0]   = wdata & `HHI_WMASK;
        `OFF_MATCH1: match_nxt[1] = wdata & `MATCH_WMASK;
        `OFF_HLO1:   hlo_nxt[1]   = wdata;
        `OFF_HHI1:   hhi_nxt[1]   = wdata & `HHI_WMASK;
        `OFF_ICTRL:  ictrl_nxt    = wdata & `ICTRL_WMASK;
        `OFF_EVMASK: evmask_nxt   = wdata[`EV_W-1:0];
        default: ;
      endcase
    end
    irq_event_nxt = |(evstat_nxt & evmask_nxt);
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_en) begin
      unique case (addr)
        `OFF_PRIO0:  rdata_nxt = prio_r[0];
        `OFF_PRIO1:  rdata_nxt = prio_r[1];
        `OFF_PRIO2:  rdata_nxt = prio_r[2];
        `OFF_PRIO3:  rdata_nxt = prio_r[3];
        `OFF_PRIO4:  rdata_nxt = prio_r[4];
        `OFF_VBASE:  rdata_nxt = vbase_r;
        `OFF_MATCH0: rdata_nxt = match_r[0];
        `OFF_HLO0:   rdata_nxt = hlo_r[0];
        `OFF_HHI0:   rdata_nxt = hhi_r[0];
        `OFF_MATCH1: rdata_nxt = match_r[1];
        `OFF_HLO1:   rdata_nxt = hlo_r[1];
        `OFF_HHI1:   rdata_nxt = hhi_r[1];
        `OFF_IRQP0:  rdata_nxt = irq_src[15:0];
        `OFF_IRQP1:  rdata_nxt = irq_src[31:16];
        `OFF_IRQP2:  rdata_nxt = {2'h0, irq_src[45:32]};
        `OFF_ICTRL:  rdata_nxt = {core_irq_r, core_level_r, 6'h00, ictrl_r[0], core_vector_r[5:0]};
        `OFF_EVSTAT: rdata_nxt = {13'h0000, evstat_r};
        `OFF_EVMASK: rdata_nxt = {13'h0000, evmask_r};
        default:     rdata_nxt = 16'h0000;
      endcase
    end
  end

  // All state registers; the boot strobe is the only one that resets high.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < `NUM_PRIO; k++) begin
        prio_r[k] <= `PRIO_RST;
      end
      for (int k = 0; k < 2; k++) begin
        match_r[k] <= '0;
        hlo_r[k]   <= '0;
        hhi_r[k]   <= '0;
      end
      vbase_r       <= '0;
      ictrl_r       <= 16'h0000;
      evstat_r      <= '0;
      evmask_r      <= '0;
      rdata_r       <= 16'h0000;
      irq_event_r   <= 1'b0;
      state_r       <= ST_IDLE;
      core_irq_r    <= 1'b0;
      core_level_r  <= 2'h0;
      core_vector_r <= '0;
      vector_addr_r <= '0;
      fast_r        <= 1'b0;
      wake_req_r    <= 1'b0;
      low_power_r   <= 1'b0;
      en_snap_r     <= '0;
      boot_drive_r  <= 1'b1;
      boot_addr_r   <= `BOOT_ADDR;
    end else begin
      for (int k = 0; k < `NUM_PRIO; k++) begin
        prio_r[k] <= prio_nxt[k];
      end
      for (int k = 0; k < 2; k++) begin
        match_r[k] <= match_nxt[k];
        hlo_r[k]   <= hlo_nxt[k];
        hhi_r[k]   <= hhi_nxt[k];
      end
      vbase_r       <= vbase_nxt;
      ictrl_r       <= ictrl_nxt;
      evstat_r      <= evstat_nxt;
      evmask_r      <= evmask_nxt;
      rdata_r       <= rdata_nxt;
      irq_event_r   <= irq_event_nxt;
      state_r       <= state_nxt;
      core_irq_r    <= core_irq_nxt;
      core_level_r  <= core_level_nxt;
      core_vector_r <= core_vector_nxt;
      vector_addr_r <= vector_addr_nxt;
      fast_r        <= fast_nxt;
      wake_req_r    <= wake_req_nxt;
      low_power_r   <= low_power;
      en_snap_r     <= en_snap_nxt;
      boot_drive_r  <= boot_drive_nxt;
      boot_addr_r   <= `BOOT_ADDR;
    end
  end

endmodule

/* interrupt_arbiter_alias_cfg.svh */
// Constants of the priority interrupt controller: offsets, reset values, masks.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
`define NUM_SRC       46
`define FIXED_SRC     6
`define NUM_PRIO      5
`define ADDR_W        5
`define VADDR_W       21
`define VEC_W         7
`define OFF_PRIO0     5'h00
`define OFF_PRIO1     5'h01
`define OFF_PRIO2     5'h02
`define OFF_PRIO3     5'h03
`define OFF_PRIO4     5'h04
`define OFF_VBASE     5'h05
`define OFF_MATCH0    5'h06
`define OFF_HLO0      5'h07
`define OFF_HHI0      5'h08
`define OFF_MATCH1    5'h09
`define OFF_HLO1      5'h0A
`define OFF_HHI1      5'h0B
`define OFF_IRQP0     5'h0C
`define OFF_IRQP1     5'h0D
`define OFF_IRQP2     5'h0E
`define OFF_ICTRL     5'h12
`define OFF_EVSTAT    5'h13
`define OFF_EVMASK    5'h14
`define PRIO_RST      16'h0000
`define PRIO0_WMASK   16'hC3FF
`define PRIO1_WMASK   16'hFCFF
`define PRIO_WMASK    16'hFFFF
`define HI_RANGE      46'h0000000007C0
`define MATCH_WMASK   16'h007F
`define HHI_WMASK     16'h001F
`define VBASE_WMASK   16'h7FFF
`define ICTRL_WMASK   16'h0001
`define EV_W          3
`define BOOT_ADDR     21'h000000
`define LVL_FAST      2'h2
`define LVL_TOP       2'h3
`endif

/* interrupt_arbiter_alias_pkg.sv */
// Types shared by the priority interrupt controller.
// Assumes the constants header sits in the same folder.
`include "interrupt_arbiter_alias_cfg.svh"
package irq_ctrl_pkg;
  typedef enum logic {ST_IDLE, ST_PRESENT} pres_state_e;
  typedef logic [1:0] lvl_t;
endpackage

/* interrupt_arbiter_alias_monitor.sv */
// Checker of the interrupt controller's port timing.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/10ps
`include "interrupt_arbiter_alias_cfg.svh"
module irq_ctrl_monitor
  import irq_ctrl_pkg::*;
(
  input wire logic                mclk,
  input wire logic                sys_rst,
  input wire logic [`NUM_SRC-1:0] irq_src,
  input wire logic [1:0]          core_mask,
  input wire logic                core_ack,
  input wire logic                low_power,
  input wire logic                rd_en,
  input wire logic [15:0]         rdata_r,
  input wire logic                core_irq_r,
  input wire logic [1:0]          core_level_r,
  input wire logic [`VEC_W-1:0]   core_vector_r,
  input wire logic [`VADDR_W-1:0] vector_addr_r,
  input wire logic                fast_r,
  input wire logic                wake_req_r,
  input wire logic                boot_drive_r,
  input wire logic [`VADDR_W-1:0] boot_addr_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // A presentation must not move under the core before it is taken.
  property p_hold;
    core_irq_r && !core_ack |=> core_irq_r && $stable(core_vector_r)
      && $stable(vector_addr_r) && $stable(core_level_r);
  endproperty
  property p_drop;
    core_irq_r && core_ack |=> !core_irq_r && !fast_r;
  endproperty
  property p_mask;
    $rose(core_irq_r) |-> core_level_r >= $past(core_mask);
  endproperty
  property p_addr;
    $rose(core_irq_r) && !fast_r |-> vector_addr_r[5:0] == core_vector_r[5:0];
  endproperty
  property p_fast;
    fast_r |-> core_irq_r && core_level_r == `LVL_FAST;
  endproperty
  property p_wake_off;
    !low_power |=> !wake_req_r;
  endproperty
  property p_wake_src;
    $rose(wake_req_r) |-> $past(low_power) && $past(irq_src) != '0;
  endproperty
  // The edge that releases reset still sees the strobe from reset, so it starts the one attempt.
  property p_boot;
    boot_drive_r && !sys_rst |=> !boot_drive_r && boot_addr_r == `BOOT_ADDR;
  endproperty
  property p_rdata;
    !$past(rd_en) |-> rdata_r == 16'h0000;
  endproperty
  a_hold: assert property (p_hold) else $error("presentation moved");
  a_drop: assert property (p_drop) else $error("no drop after ack");
  a_mask: assert property (p_mask) else $error("masked level shown");
  a_addr: assert property (p_addr) else $error("bad vector offset");
  a_fast: assert property (p_fast) else $error("fast off level 2");
  a_wake_off: assert property (p_wake_off) else $error("wake outside low power");
  a_wake_src: assert property (p_wake_src) else $error("wake without source");
  a_boot: assert property (p_boot) else $error("boot drive wrong");
  a_rdata: assert property (p_rdata) else $error("read data not idle");
  c_fast: cover property (fast_r && core_ack);
  c_wake: cover property ($rose(wake_req_r));
  c_take: cover property (core_irq_r && core_ack && !fast_r);
endmodule
bind priority_interrupt_controller irq_ctrl_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst),
  .irq_src(irq_src), .core_mask(core_mask), .core_ack(core_ack), .low_power(low_power),
  .rd_en(rd_en), .rdata_r(rdata_r), .core_irq_r(core_irq_r), .core_level_r(core_level_r),
  .core_vector_r(core_vector_r), .vector_addr_r(vector_addr_r), .fast_r(fast_r),
  .wake_req_r(wake_req_r), .boot_drive_r(boot_drive_r), .boot_addr_r(boot_addr_r));

/* core_model.sv */
// Model of the core's interrupt acknowledge.
// Assumes the controller holds core_irq_r until it samples core_ack.
`timescale 1ns/10ps
module core_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       core_irq_r,
  input  wire logic [3:0] ack_dly,
  output logic            core_ack
);
  logic [3:0] wait_r;
  // One acknowledge per presentation, after ack_dly waiting cycles.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r   <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= core_irq_r && !core_ack && (wait_r >= ack_dly);
      wait_r   <= (core_irq_r && !core_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* priority_interrupt_controller_tb.sv */
// Self-checking bench of the interrupt controller with a core model.
// Assumes the package, constants header and checker are compiled first.
`timescale 1ns/10ps
`include "interrupt_arbiter_alias_cfg.svh"
module priority_interrupt_controller_tb;
  import irq_ctrl_pkg::*;
  localparam logic [14:0] VB = 15'h1234;
  logic [`NUM_SRC-1:0] irq_src;
  logic [1:0] core_mask, core_level_r;
  logic mclk, sys_rst, core_ack, low_power, wr_en, rd_en, core_irq_r, fast_r;
  logic wake_req_r, boot_drive_r, irq_event_r;
  logic [4:0] addr;
  logic [15:0] wdata, rdata_r;
  logic [6:0] core_vector_r;
  logic [20:0] vector_addr_r, boot_addr_r;
  logic [3:0] ack_dly;
  int mismatches, compares, cyc;
  priority_interrupt_controller dut (.mclk(mclk), .sys_rst(sys_rst), .irq_src(irq_src),
    .core_mask(core_mask), .core_ack(core_ack), .low_power(low_power), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r), .core_irq_r(core_irq_r),
    .core_level_r(core_level_r), .core_vector_r(core_vector_r), .vector_addr_r(vector_addr_r),
    .fast_r(fast_r), .wake_req_r(wake_req_r), .boot_drive_r(boot_drive_r),
    .boot_addr_r(boot_addr_r), .irq_event_r(irq_event_r));
  core_model core (.mclk(mclk), .sys_rst(sys_rst), .core_irq_r(core_irq_r),
    .ack_dly(ack_dly), .core_ack(core_ack));
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
    @(posedge mclk) wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk) begin addr <= a; rd_en <= 1'b1; end
    @(posedge mclk) rd_en <= 1'b0;
    #1 chk(rdata_r, e);
  endtask
  task automatic raise(input int v);
    @(posedge mclk) irq_src[v] <= 1'b1;
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 20 && core_irq_r !== lvl; i++) begin @(posedge mclk); #1; end
    chk(core_irq_r, lvl);
  endtask
  task automatic quiet();
    repeat (8) @(posedge mclk);
    #1 chk(core_irq_r, 1'b0);
  endtask
  // Checks one presentation, withdraws its source and waits for the drop.
  task automatic present(input int v, input logic [1:0] l, input logic [20:0] a,
                         input logic f);
    wait_irq(1'b1);
    chk(core_vector_r, v);
    chk(core_level_r, l);
    chk(vector_addr_r, a);
    chk(fast_r, f);
    @(posedge mclk) irq_src[v] <= 1'b0;
    wait_irq(1'b0);
  endtask
  task automatic t_regs();
    rd(5'h00, 16'h0000);
    wr(5'h00, 16'hFFFF);
    rd(5'h00, 16'hC3FF);
    wr(5'h01, 16'hFFFF);
    rd(5'h01, 16'hFCFF);
    rd(5'h1F, 16'h0000);
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h0000);
  endtask
  task automatic t_encode();
    wr(5'h05, {1'b0, VB});
    wr(5'h02, 16'hFFFF);
    @(posedge mclk) begin irq_src[25] <= 1'b1; irq_src[23] <= 1'b1; end
    present(23, 2'h2, {VB, 6'h17}, 1'b0);
    present(25, 2'h2, {VB, 6'h19}, 1'b0);
  endtask
  // Higher levels win over lower numbers; the core mask gates levels.
  task automatic t_levels();
    wr(5'h00, 16'h0004);
    ack_dly <= 4'h0;
    @(posedge mclk) begin irq_src[7] <= 1'b1; irq_src[29] <= 1'b1; end
    present(29, 2'h2, {VB, 6'h1D}, 1'b0);
    present(7, 2'h1, {VB, 6'h07}, 1'b0);
    @(posedge mclk) begin core_mask <= 2'h3; irq_src[7] <= 1'b1; irq_src[22] <= 1'b1; end
    raise(0);
    present(0, 2'h3, {VB, 6'h00}, 1'b0);
    quiet();
    @(posedge mclk) core_mask <= 2'h2;
    present(22, 2'h2, {VB, 6'h16}, 1'b0);
    quiet();
    @(posedge mclk) core_mask <= 2'h0;
    present(7, 2'h1, {VB, 6'h07}, 1'b0);
    ack_dly <= 4'h5;
  endtask
  task automatic t_fast();
    wr(5'h06, 16'h0019);
    wr(5'h07, 16'hBEEF);
    wr(5'h08, 16'h0015);
    wr(5'h09, 16'h001B);
    wr(5'h0A, 16'hCAFE);
    wr(5'h0B, 16'h0003);
    raise(25);
    present(25, 2'h2, {5'h15, 16'hBEEF}, 1'b1);
    raise(27);
    present(27, 2'h2, {5'h03, 16'hCAFE}, 1'b1);
    wr(5'h09, 16'h0007);
    raise(7);
    present(7, 2'h1, {VB, 6'h07}, 1'b0);
    wr(5'h12, 16'h0001);
    raise(0);
    quiet();
    wr(5'h12, 16'h0000);
    present(0, 2'h3, {VB, 6'h00}, 1'b0);
  endtask
  // Only sources enabled at entry may wake; late enables stay silent.
  task automatic t_wake();
    @(posedge mclk) low_power <= 1'b1;
    raise(30);
    repeat (4) @(posedge mclk);
    #1 chk(wake_req_r, 1'b0);
    wr(5'h03, 16'hFFFF);
    repeat (4) @(posedge mclk);
    #1 chk(wake_req_r, 1'b0);
    raise(22);
    repeat (3) @(posedge mclk);
    #1 chk(wake_req_r, 1'b1);
    @(posedge mclk) low_power <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(wake_req_r, 1'b0);
    @(posedge mclk) irq_src <= '0;
    repeat (20) @(posedge mclk);
  endtask
  task automatic t_event();
    wr(5'h14, 16'h0001);
    rd(5'h13, 16'h0007);
    chk(irq_event_r, 1'b1);
    wr(5'h14, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk(irq_event_r, 1'b0);
    wr(5'h14, 16'h0002);
    wr(5'h13, 16'h0007);
    rd(5'h13, 16'h0000);
    chk(irq_event_r, 1'b0);
  endtask
  // Free-running clock of 8 ns.
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // The cycle ceiling cuts a hang short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      end_sim();
    end
  end
  // Reset, then every scenario in turn.
  initial begin
    {sys_rst, irq_src, core_mask, low_power, addr, wdata, wr_en, rd_en} = '0;
    sys_rst = 1'b1;
    ack_dly = 4'h3;
    {mismatches, compares, cyc} = '0;
    repeat (8) @(posedge mclk);
    #1 chk(boot_drive_r, 1'b1);
    @(posedge mclk) sys_rst <= 1'b0;
    @(posedge mclk);
    #1 chk(boot_drive_r, 1'b0);
    chk(boot_addr_r, `BOOT_ADDR);
    t_regs();
    t_encode();
    t_levels();
    t_fast();
    t_wake();
    t_event();
    end_sim();
  end
endmodule
